// ==== include/midi_uart_pkg.sv ====
package midi_uart_pkg;

  // Clocking and serial timing.
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned BAUD_HZ = 31_250;
  localparam int unsigned OVERSAMPLE = 16;
  localparam int unsigned TICK_CYCLES = CLK_HZ / (BAUD_HZ * OVERSAMPLE);
  localparam logic [7:0] TICK_LAST = 8'(TICK_CYCLES - 1);
  localparam logic [3:0] TICK_MID = 4'h7;
  localparam logic [3:0] TICK_END = 4'hf;
  localparam logic [2:0] LAST_DATA_BIT = 3'h7;
  localparam logic SERIAL_IDLE = 1'b1;

  // Host address decode.
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DEC_W = 10;
  localparam logic OFS_DATA = 1'h0;
  localparam logic OFS_CMD = 1'h1;

  // FIFO geometry.
  localparam int unsigned FIFO_DEPTH = 16;
  localparam logic [4:0] FIFO_FULL_CNT = 5'h10;

  // Commands and answers.
  localparam logic [7:0] CMD_ENTER_UART = 8'h3f;
  localparam logic [7:0] CMD_EXIT_UART = 8'hff;
  localparam logic [7:0] ACK_BYTE = 8'hfe;

  // Status byte layout.
  localparam int unsigned STAT_RX_EMPTY = 7;
  localparam int unsigned STAT_TX_FULL = 6;
  localparam int unsigned STAT_ECHO_W = 6;

  // Values after reset.
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic RST_UART_MODE = 1'b0;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_START = 2'b01,
    RX_DATA = 2'b10,
    RX_STOP = 2'b11
  } rx_state_t;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_START = 2'b01,
    TX_DATA = 2'b10,
    TX_STOP = 2'b11
  } tx_state_t;

endpackage

// ==== logic/midi_uart_host_port.sv ====
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// - Decode two locations, nine address bits compared with the base.
// - Nonzero upper address bits reject the access.
// - Offset zero data, offset one command/status.
// - Offset one: write command, read status.
// - Sixteen-byte FIFO in each direction.
// - Accepted command writes queue an acknowledge outside UART mode; in it only FFh does.
// - Status low six bits echo last command.
// - Status bit 6 set while transmit FIFO full.
// - Status bit 7 set while receive FIFO empty.
// - Receive FIFO write raises host interrupt.
// - Receive FIFO fed by serial and acknowledges.
// - Data port read clears pending interrupt.
// - Serial link fixed at 31.25 kbaud.
// - One start, eight data, one stop bit.
// - Serialize transmit bytes, deserialize received characters.
// - Reset enters non-UART mode, data writes ignored.
// - Command 3Fh enters UART mode, acknowledges FEh.
// - Command FFh leaves UART mode; others ignored.
// - Full receive FIFO overwrites its last entry.
module midi_uart_host_port
  import midi_uart_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [DEC_W-1:0] midi_port_base,
  input wire logic [ADDR_W-1:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [7:0] bus_rdata,
  output logic bus_rdata_valid,
  output logic irq,
  input wire logic serial_in_pin,
  output logic serial_out_pin
);

  // All state lives in one record; the process below fills s_d and the
  // single register stage captures it, so every output is a flip-flop.
  typedef struct packed {
    logic [1:0] in_sync;
    logic uart_mode;
    logic [STAT_ECHO_W-1:0] cmd_echo;
    logic ack_pend;
    logic irq;
    logic [7:0] rdata;
    logic rdata_valid;
    logic [7:0] last_rd;
    logic [FIFO_DEPTH-1:0][7:0] rx_mem;
    logic [3:0] rx_wp;
    logic [3:0] rx_rp;
    logic [4:0] rx_cnt;
    logic [FIFO_DEPTH-1:0][7:0] tx_mem;
    logic [3:0] tx_wp;
    logic [3:0] tx_rp;
    logic [4:0] tx_cnt;
    logic [7:0] tick_cnt;
    logic tick;
    rx_state_t rx_st;
    logic [3:0] rx_tk;
    logic [2:0] rx_bit;
    logic [7:0] rx_sh;
    tx_state_t tx_st;
    logic [3:0] tx_tk;
    logic [2:0] tx_bit;
    logic [7:0] tx_sh;
    logic sout;
  } state_t;

  state_t s_q;
  state_t s_d;

  // Counts run to sixteen, one more than a pointer holds, so full and
  // empty are told apart without giving up a slot.
  function automatic logic [3:0] ptr_inc(input logic [3:0] p);
    ptr_inc = 4'(p + 4'h1);
  endfunction

  function automatic logic fifo_full(input logic [4:0] cnt);
    fifo_full = (cnt == FIFO_FULL_CNT);
  endfunction

  function automatic logic fifo_empty(input logic [4:0] cnt);
    fifo_empty = (cnt == 5'h00);
  endfunction

  logic hit;
  logic ofs;
  logic data_wr;
  logic data_rd;
  logic cmd_wr;
  logic stat_rd;
  logic rx_done;
  logic rx_push;
  logic [7:0] rx_byte;
  logic rx_pop;
  logic tx_push;
  logic tx_pop;
  logic in_bit;

  // Host decode. Bit 0 of the base is ignored, so the pair starts on an
  // even address; the upper six address bits must be zero, so the port
  // has no aliases higher up the I/O space.
  always_comb begin
    hit = (bus_addr[ADDR_W-1:DEC_W] == '0) &&
          (bus_addr[DEC_W-1:1] == midi_port_base[DEC_W-1:1]);
    ofs = bus_addr[0];
    data_wr = hit && bus_wr && (ofs == OFS_DATA);
    data_rd = hit && bus_rd && (ofs == OFS_DATA);
    cmd_wr = hit && bus_wr && (ofs == OFS_CMD);
    stat_rd = hit && bus_rd && (ofs == OFS_CMD);
  end

  always_comb begin
    s_d = s_q;
    in_bit = s_q.in_sync[1];
    rx_done = 1'b0;
    rx_push = 1'b0;
    rx_byte = RST_BYTE;
    rx_pop = 1'b0;
    tx_push = 1'b0;
    tx_pop = 1'b0;

    // Pin synchroniser; only the second stage is read.
    s_d.in_sync = {s_q.in_sync[0], serial_in_pin};

    // Oversampling tick, sixteen per bit time. The divider runs freely;
    // both directions step on its pulse, so a start edge is seen at most
    // one tick late.
    s_d.tick = 1'b0;
    if (s_q.tick_cnt == TICK_LAST) begin
      s_d.tick_cnt = 8'h00;
      s_d.tick = 1'b1;
    end else begin
      s_d.tick_cnt = 8'(s_q.tick_cnt + 8'h01);
    end

    // Receiver. A low sample is checked again half a bit later, then the
    // line is sampled every sixteenth tick, near the centre of each bit.
    if (s_q.tick) begin
      unique case (s_q.rx_st)
        RX_IDLE: begin
          if (!in_bit) begin
            s_d.rx_st = RX_START;
            s_d.rx_tk = 4'h0;
          end
        end
        RX_START: begin
          s_d.rx_tk = 4'(s_q.rx_tk + 4'h1);
          if (s_q.rx_tk == TICK_MID) begin
            if (in_bit) begin
              // A glitch shorter than half a bit is not a start bit.
              s_d.rx_st = RX_IDLE;
            end else begin
              s_d.rx_st = RX_DATA;
              s_d.rx_tk = 4'h0;
              s_d.rx_bit = 3'h0;
            end
          end
        end
        RX_DATA: begin
          s_d.rx_tk = 4'(s_q.rx_tk + 4'h1);
          if (s_q.rx_tk == TICK_END) begin
            s_d.rx_sh = {in_bit, s_q.rx_sh[7:1]};
            s_d.rx_bit = 3'(s_q.rx_bit + 3'h1);
            if (s_q.rx_bit == LAST_DATA_BIT) begin
              s_d.rx_st = RX_STOP;
            end
          end
        end
        RX_STOP: begin
          s_d.rx_tk = 4'(s_q.rx_tk + 4'h1);
          if (s_q.rx_tk == TICK_END) begin
            s_d.rx_st = RX_IDLE;
            // A low stop bit is a framing error; the character is lost.
            rx_done = in_bit;
          end
        end
      endcase
    end

    // Command port.
    if (cmd_wr) begin
      s_d.cmd_echo = bus_wdata[STAT_ECHO_W-1:0];
    end

    // Acknowledge queue yields to a serial byte in the same cycle.
    // Only one acknowledge can wait; two commands before it drains
    // leave a single acknowledge behind.
    if (rx_done) begin
      rx_push = 1'b1;
      rx_byte = s_q.rx_sh;
    end else if (s_q.ack_pend) begin
      rx_push = 1'b1;
      rx_byte = ACK_BYTE;
      s_d.ack_pend = 1'b0;
    end

    if (cmd_wr) begin
      if (!s_q.uart_mode) begin
        s_d.ack_pend = 1'b1;
        if (bus_wdata == CMD_ENTER_UART) begin
          s_d.uart_mode = 1'b1;
        end
      end else if (bus_wdata == CMD_EXIT_UART) begin
        s_d.ack_pend = 1'b1;
        s_d.uart_mode = 1'b0;
      end
    end

    // Host reads, answered one cycle after the strobe. A data read on an
    // empty FIFO repeats the last byte taken and pops nothing.
    s_d.rdata_valid = data_rd || stat_rd;
    if (data_rd) begin
      if (!fifo_empty(s_q.rx_cnt)) begin
        rx_pop = 1'b1;
        s_d.rdata = s_q.rx_mem[s_q.rx_rp];
        s_d.last_rd = s_q.rx_mem[s_q.rx_rp];
      end else begin
        s_d.rdata = s_q.last_rd;
      end
    end else if (stat_rd) begin
      s_d.rdata = {fifo_empty(s_q.rx_cnt),
                   fifo_full(s_q.tx_cnt),
                   s_q.cmd_echo};
    end

    // Receive FIFO. When full, the newest entry is replaced, unless a pop
    // in the same cycle makes room; then the byte is queued normally.
    if (rx_pop) begin
      s_d.rx_rp = ptr_inc(s_q.rx_rp);
    end
    if (rx_push) begin
      if (fifo_full(s_q.rx_cnt) && !rx_pop) begin
        s_d.rx_mem[4'(s_q.rx_wp - 4'h1)] = rx_byte;
      end else begin
        s_d.rx_mem[s_q.rx_wp] = rx_byte;
        s_d.rx_wp = ptr_inc(s_q.rx_wp);
      end
    end
    if (rx_push && !rx_pop && !fifo_full(s_q.rx_cnt)) begin
      s_d.rx_cnt = 5'(s_q.rx_cnt + 5'h01);
    end else if (rx_pop && !rx_push) begin
      s_d.rx_cnt = 5'(s_q.rx_cnt - 5'h01);
    end

    // Interrupt: a push in the clearing cycle keeps it raised.
    if (rx_push) begin
      s_d.irq = 1'b1;
    end else if (data_rd) begin
      s_d.irq = 1'b0;
    end

    // Transmit FIFO; data writes outside UART mode are dropped.
    // A write into a full FIFO is lost, so the host must watch the flag.
    tx_push = data_wr && s_q.uart_mode && !fifo_full(s_q.tx_cnt);
    tx_pop = (s_q.tx_st == TX_IDLE) && s_q.tick &&
             !fifo_empty(s_q.tx_cnt);
    if (tx_push) begin
      s_d.tx_mem[s_q.tx_wp] = bus_wdata;
      s_d.tx_wp = ptr_inc(s_q.tx_wp);
    end
    if (tx_pop) begin
      s_d.tx_rp = ptr_inc(s_q.tx_rp);
    end
    if (tx_push && !tx_pop) begin
      s_d.tx_cnt = 5'(s_q.tx_cnt + 5'h01);
    end else if (tx_pop && !tx_push) begin
      s_d.tx_cnt = 5'(s_q.tx_cnt - 5'h01);
    end

    // Transmitter. A byte leaves the FIFO only on a tick with the line
    // idle, so characters follow each other with at most one tick between.
    if (s_q.tick) begin
      unique case (s_q.tx_st)
        TX_IDLE: begin
          if (tx_pop) begin
            s_d.tx_sh = s_q.tx_mem[s_q.tx_rp];
            s_d.tx_st = TX_START;
            s_d.tx_tk = 4'h0;
            s_d.sout = 1'b0;
          end
        end
        TX_START: begin
          s_d.tx_tk = 4'(s_q.tx_tk + 4'h1);
          if (s_q.tx_tk == TICK_END) begin
            s_d.tx_st = TX_DATA;
            s_d.tx_bit = 3'h0;
            s_d.sout = s_q.tx_sh[0];
            s_d.tx_sh = {1'b0, s_q.tx_sh[7:1]};
          end
        end
        TX_DATA: begin
          s_d.tx_tk = 4'(s_q.tx_tk + 4'h1);
          if (s_q.tx_tk == TICK_END) begin
            s_d.tx_bit = 3'(s_q.tx_bit + 3'h1);
            if (s_q.tx_bit == LAST_DATA_BIT) begin
              s_d.tx_st = TX_STOP;
              s_d.sout = SERIAL_IDLE;
            end else begin
              s_d.sout = s_q.tx_sh[0];
              s_d.tx_sh = {1'b0, s_q.tx_sh[7:1]};
            end
          end
        end
        TX_STOP: begin
          s_d.tx_tk = 4'(s_q.tx_tk + 4'h1);
          if (s_q.tx_tk == TICK_END) begin
            s_d.tx_st = TX_IDLE;
          end
        end
      endcase
    end

    // Synchronous reset overrides every next value; the line and the
    // synchroniser come up at the idle level, so no false start is seen.
    if (!nrst) begin
      s_d = '0;
      s_d.in_sync = {2{SERIAL_IDLE}};
      s_d.sout = SERIAL_IDLE;
      s_d.uart_mode = RST_UART_MODE;
      s_d.rdata = RST_BYTE;
      s_d.last_rd = RST_BYTE;
      s_d.rx_st = RX_IDLE;
      s_d.tx_st = TX_IDLE;
    end
  end

  always_ff @(posedge clk_sys) begin
    s_q <= s_d;
  end

  // Outputs come straight from the register stage.
  assign bus_rdata = s_q.rdata;
  assign bus_rdata_valid = s_q.rdata_valid;
  assign irq = s_q.irq;
  assign serial_out_pin = s_q.sout;

endmodule

`default_nettype wire

// ==== testbench/midi_uart_host_port_assertions.sv ====
`timescale 1ns/100ps
`default_nettype none
module midi_uart_host_port_assertions
  import midi_uart_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [DEC_W-1:0] midi_port_base,
  input wire logic [ADDR_W-1:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [7:0] bus_rdata,
  input wire logic bus_rdata_valid,
  input wire logic irq,
  input wire logic serial_in_pin,
  input wire logic serial_out_pin
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  logic hit, hit_rd, cmd_wr, stat_rd, prev_q;
  logic [15:0] run_q;
  assign hit = bus_addr[15:10] == 6'h0 && bus_addr[9:1] == midi_port_base[9:1];
  assign hit_rd = hit && bus_rd;
  assign cmd_wr = hit && bus_wr && bus_addr[0] == OFS_CMD;
  assign stat_rd = hit_rd && bus_addr[0] == OFS_CMD;
  // Length of the current run of one level on the serial output.
  always_ff @(posedge clk_sys) begin
    prev_q <= serial_out_pin;
    run_q <= !nrst ? 16'h0 : serial_out_pin != prev_q ? 16'h1 : run_q + 16'h1;
  end
  AST_RD_ANSWER: assert property (hit_rd |=> bus_rdata_valid)
    else $error("hit read got no answer");
  AST_NO_ALIAS: assert property (!hit_rd |=> !bus_rdata_valid)
    else $error("answer without a hit read");
  AST_RD_HOLD: assert property (!hit_rd |=> $stable(bus_rdata))
    else $error("read data moved without a read");
  AST_ECHO: assert property (cmd_wr ##1 stat_rd
    |=> bus_rdata[5:0] == $past(bus_wdata[5:0], 2))
    else $error("status does not echo the command");
  AST_EXIT_ACK: assert property (
    cmd_wr && bus_wdata == CMD_EXIT_UART |-> ##[1:3] irq)
    else $error("exit command raised no interrupt");
  AST_IRQ_CLEAR: assert property (
    $fell(irq) |-> $past(hit_rd && bus_addr[0] == OFS_DATA))
    else $error("interrupt fell without a data read");
  AST_BIT_TIME: assert property ($rose(serial_out_pin)
    |-> run_q % 16'(TICK_CYCLES * OVERSAMPLE) == 16'h0)
    else $error("low run is not whole bit times");
  AST_RESET_IDLE: assert property ($rose(nrst) |-> serial_out_pin
    && !irq && !bus_rdata_valid && bus_rdata == RST_BYTE)
    else $error("outputs not idle after reset");
  cover property (hit_rd && bus_addr[0] == OFS_DATA);
  cover property ($rose(irq));
  cover property ($fell(serial_out_pin));
endmodule
bind midi_uart_host_port midi_uart_host_port_assertions chk (
  .clk_sys(clk_sys), .nrst(nrst), .midi_port_base(midi_port_base),
  .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
  .bus_rd(bus_rd), .bus_rdata(bus_rdata), .bus_rdata_valid(bus_rdata_valid),
  .irq(irq), .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin));
`default_nettype wire

// ==== testbench/midi_instrument.sv ====
`timescale 1ns/100ps
`default_nettype none
// Far-side instrument: takes one character and sends it straight back.
module midi_instrument (
  input wire logic serial_out_pin,
  output logic serial_in_pin
);
  logic [7:0] b;
  initial begin
    serial_in_pin = 1'b1;
    forever begin
      @(negedge serial_out_pin);
      #16000;
      for (int i = 0; i < 8; i++) begin
        #32000 b[i] = serial_out_pin;
      end
      #32000 serial_in_pin = 1'b0;
      for (int i = 0; i < 8; i++) begin
        #32000 serial_in_pin = b[i];
      end
      #32000 serial_in_pin = 1'b1;
      #32000;
    end
  end
endmodule
`default_nettype wire

// ==== testbench/tb_midi_uart_host_port.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb_midi_uart_host_port;
  logic clk_sys = 0, nrst = 0, bus_wr = 0, bus_rd = 0, irq, valid, sin, sout;
  logic [9:0] base = 0;
  logic [15:0] bus_addr = 0;
  logic [7:0] bus_wdata = 0, bus_rdata, c, t;
  logic [31:0] r = 32'h5352;
  logic [7:0] exp_q[$];
  int err_count = 0, check_count = 0, cyc = 0;
  midi_uart_host_port uut (.clk_sys(clk_sys), .nrst(nrst),
    .midi_port_base(base), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .bus_rdata_valid(valid), .irq(irq), .serial_in_pin(sin),
    .serial_out_pin(sout));
  midi_instrument peer (.serial_out_pin(sout), .serial_in_pin(sin));
  initial forever #5 clk_sys = ~clk_sys;
  function automatic logic [31:0] lfsr(logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic check(logic [7:0] seen, logic [7:0] want);
    check_count++;
    if (seen !== want) begin
      err_count++;
      $display("FAIL %0t: saw %h expected %h", $time, seen, want);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // One bus cycle per call; strobes stay until the next call changes them.
  task automatic acc(logic w, logic rd, logic [15:0] a, logic [7:0] d);
    @(posedge clk_sys);
    #1 bus_wr = w;
    bus_rd = rd;
    bus_addr = a;
    bus_wdata = d;
  endtask
  function automatic logic [15:0] ad(logic o);
    return {6'h0, base[9:1], o};
  endfunction
  task automatic wr(logic o, logic [7:0] d);
    acc(1'b1, 1'b0, ad(o), d);
  endtask
  task automatic rd(logic o, logic [7:0] e);
    exp_q.push_back(e);
    acc(1'b0, 1'b1, ad(o), 8'h00);
  endtask
  task automatic idle(int n);
    repeat (n) acc(1'b0, 1'b0, 16'h0, 8'h00);
  endtask
  always @(negedge clk_sys) begin
    cyc++;
    if (cyc == 100000) begin
      err_count++;
      $display("FAIL %0t: run took too long", $time);
      close_out();
    end
    if (valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        err_count++;
        $display("FAIL %0t: answer nobody asked for", $time);
      end else
        check(bus_rdata, exp_q.pop_front());
    end
  end
  initial begin
    r = lfsr(r);
    base = r[9:0] & 10'h3fe;
    repeat (4) @(posedge clk_sys);
    #1 nrst = 1;
    rd(1'b1, 8'h80);
    acc(1'b0, 1'b1, ad(1'b0) | 16'h8000, 8'h00);
    acc(1'b0, 1'b1, ad(1'b0) ^ 16'h0200, 8'h00);
    wr(1'b0, 8'h55);
    r = lfsr(r);
    c = {2'b01, r[5:0]};
    for (int i = 0; i < 17; i++) begin
      wr(1'b1, c);
      idle(2);
    end
    check({7'h0, irq}, 8'h01);
    rd(1'b1, {2'b00, c[5:0]});
    for (int i = 0; i < 17; i++) rd(1'b0, 8'hfe);
    rd(1'b1, {2'b10, c[5:0]});
    idle(2);
    check({7'h0, irq}, 8'h00);
    $display("test decode and acknowledge done");
    wr(1'b1, 8'h3f);
    rd(1'b1, 8'hbf);
    idle(3);
    rd(1'b0, 8'hfe);
    r = lfsr(r);
    t = r[7:0];
    wr(1'b0, t);
    idle(250);
    for (int i = 1; i < 17; i++) wr(1'b0, t + 8'(i));
    rd(1'b1, 8'hff);
    $display("test transmit fill done");
    for (int i = 0; i < 70000 && irq !== 1'b1; i++) idle(1);
    rd(1'b0, t);
    wr(1'b1, 8'hff);
    idle(3);
    rd(1'b0, 8'hfe);
    $display("test serial loop done");
    idle(1);
    nrst = 0;
    idle(4);
    nrst = 1;
    rd(1'b1, 8'h80);
    idle(3);
    check(8'(exp_q.size()), 8'h00);
    $display("test second reset done");
    close_out();
  end
endmodule
`default_nettype wire
